// ==== logic/hps_pkg.sv ====
`default_nettype none
package hps_pkg;
	// widths of the parallel port fields
	localparam int unsigned DATA_W   = 12;
	localparam int unsigned ADDR_W   = 5;
	localparam int unsigned REGSEL_W = 2;

	// monitor multiplexer: output channels first, then the monitor inputs
	localparam int unsigned MON_CHANNELS = 32;
	localparam int unsigned MON_INPUTS   = 4;
	localparam int unsigned MON_SOURCES  = MON_CHANNELS + MON_INPUTS;
	localparam int unsigned MON_SEL_W    = 6;
	localparam int unsigned IN_CHANNELS  = 40;

	// i2c hardware address width
	localparam int unsigned I2C_ADDR_W = 2;

	// interface mode, gray coded so parallel->spi->i2c moves one bit
	typedef enum logic [1:0] {
		HPS_MODE_PAR = 2'h0,
		HPS_MODE_SPI = 2'h1,
		HPS_MODE_I2C = 2'h3
	} hps_mode_t;

	// destination register class on the register select lines
	typedef enum logic [1:0] {
		HPS_REG_SPECIAL = 2'h0,
		HPS_REG_GAIN    = 2'h1,
		HPS_REG_OFFSET  = 2'h2,
		HPS_REG_DATA    = 2'h3
	} hps_regsel_t;

	// values after reset
	localparam hps_mode_t                MODE_RST  = HPS_MODE_PAR;
	localparam logic [DATA_W-1:0]        DATA_RST  = 12'h000;
	localparam logic [ADDR_W-1:0]        ADDR_RST  = 5'h00;
	localparam logic [REGSEL_W-1:0]      REG_RST   = 2'h0;
	localparam logic [I2C_ADDR_W-1:0]    I2C_RST   = 2'h0;
	localparam logic [MON_SOURCES-1:0]   ROUTE_RST = 36'h0_0000_0000;
endpackage
`default_nettype wire

// ==== logic/hps_mon_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// carries the monitor selection to the decoder and the switch enables back
interface hps_mon_if;
	logic                               enable;
	logic [hps_pkg::MON_SEL_W-1:0]      select;
	logic [hps_pkg::MON_SOURCES-1:0]    route;

	modport ctrl (output enable, output select, input route);
	modport dec  (input enable, input select, output route);
endinterface
`default_nettype wire

// ==== logic/hps_mon_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module hps_mon_decode (
	// selection in, switch enables out
	hps_mon_if.dec mon
);
	// one comparator per source; codes past the last source select nothing
	genvar gi;
	generate
		for (gi = 0; gi < hps_pkg::MON_SOURCES; gi++) begin : g_src
			assign mon.route[gi] = mon.enable &&
				(mon.select == hps_pkg::MON_SEL_W'(gi)); // RQ1
		end
	endgenerate
endmodule
`default_nettype wire

// ==== logic/hps_pin_select.sv ====
// Summary of operation
// RQ1 - monitor enabled routes exactly one of 36 sources to monitor output; here selects 36 to 63 route no source
// RQ2 - interface select high gives serial; protocol select picks SPI or I2C
// RQ3 - interface select low gives parallel mode
// RQ4 - parallel: select pin is level-sensitive active-low device select
// RQ5 - parallel: write on strobe rising edge only while select low
// RQ6 - SPI: shared select pin is the frame sync input
// RQ7 - SPI: chain enable pin high enables daisy-chain, level sensitive
// RQ8 - I2C: two shared pins sampled as hardware address bits
// RQ9 - parallel data bus is 12 bits, top line MSB, line zero LSB
// RQ10 - five channel address lines and two register select lines
// RQ11 - toggle mode: shared output pin picks data register A or B
// RQ12 - host keeps interface and protocol selects static while running
`timescale 1ns/10ps
`default_nettype none
module hps_pin_select (
	// clock, reset, enable
	input  wire logic                                clk_sys_i,
	input  wire logic                                resetn_i,
	input  wire logic                                clk_en_i,
	// mode straps
	input  wire logic                                interface_select_i,
	input  wire logic                                proto_select_i,
	// shared pins: select/sync/addr0 and write/chain/addr1
	input  wire logic                                shared_sel_i,
	input  wire logic                                shared_wr_i,
	// parallel bus
	input  wire logic [hps_pkg::DATA_W-1:0]          parallel_data_bus_i,
	input  wire logic [hps_pkg::ADDR_W-1:0]          channel_address_i,
	input  wire logic [hps_pkg::REGSEL_W-1:0]        register_select_i,
	input  wire logic                                toggle_mode_i,
	// two-way serial-output / bank pin
	input  wire logic                                sdo_bank_i,
	output logic                                     sdo_bank_o,
	output logic                                     sdo_bank_oe_o,
	input  wire logic                                serial_dout_i,
	// monitor control
	input  wire logic                                monitor_enable_i,
	input  wire logic [hps_pkg::MON_SEL_W-1:0]       monitor_select_i,
	// decoded roles
	output logic [1:0]                               mode_o,
	output logic                                     par_selected_o,
	output logic                                     par_write_o,
	output logic [hps_pkg::DATA_W-1:0]               par_data_o,
	output logic [hps_pkg::ADDR_W-1:0]               par_chan_o,
	output logic [hps_pkg::REGSEL_W-1:0]             par_reg_o,
	output logic                                     par_bank_b_o,
	output logic                                     frame_sync_o,
	output logic                                     spi_chain_en_o,
	output logic [hps_pkg::I2C_ADDR_W-1:0]           i2c_addr_o,
	// monitor switch enables
	output logic [hps_pkg::MON_SOURCES-1:0]          monitor_output_o,
	output logic                                     monitor_active_o
);
	hps_pkg::hps_mode_t                 mode_q, mode_d;
	logic                               wr_q, wr_d;
	logic                               wr_rise;
	logic                               sel_q, sel_d;
	logic                               write_q, write_d;
	logic [hps_pkg::DATA_W-1:0]         data_q, data_d;
	logic [hps_pkg::ADDR_W-1:0]         chan_q, chan_d;
	logic [hps_pkg::REGSEL_W-1:0]       reg_q, reg_d;
	logic                               bank_q, bank_d;
	logic                               sync_q, sync_d;
	logic                               chain_q, chain_d;
	logic [hps_pkg::I2C_ADDR_W-1:0]     i2c_q, i2c_d;
	logic                               sdo_q, sdo_d;
	logic                               sdo_oe_q, sdo_oe_d;
	logic [hps_pkg::MON_SOURCES-1:0]    route_q, route_d;
	logic                               active_q, active_d;

	hps_mon_if mon ();

	// monitor decode lives in its own module so the switch map is one loop
	hps_mon_decode u_mon_decode (
		.mon (mon.dec)
	);

	assign mon.enable = monitor_enable_i;
	assign mon.select = monitor_select_i;

	// strobe edge seen against the last sampled level
	assign wr_rise = shared_wr_i && !wr_q;

	// next values of the pin roles; mode follows the straps on every enabled cycle,
	// which is only safe because the host keeps them still while busy
	always_comb begin
		mode_d   = mode_q;
		wr_d     = shared_wr_i;
		sel_d    = 1'b0;
		write_d  = 1'b0;
		data_d   = data_q;
		chan_d   = chan_q;
		reg_d    = reg_q;
		bank_d   = bank_q;
		sync_d   = 1'b1;
		chain_d  = 1'b0;
		i2c_d    = i2c_q;
		sdo_d    = 1'b0;
		sdo_oe_d = 1'b0;
		if (!interface_select_i) begin
			mode_d = hps_pkg::HPS_MODE_PAR; // RQ3
		end else if (proto_select_i) begin
			mode_d = hps_pkg::HPS_MODE_I2C; // RQ2
		end else begin
			mode_d = hps_pkg::HPS_MODE_SPI; // RQ2
		end
		unique case (mode_q)
			hps_pkg::HPS_MODE_PAR: begin
				sel_d = !shared_sel_i; // RQ4
				if (!shared_sel_i && wr_rise) begin
					write_d = 1'b1; // RQ5
					data_d  = parallel_data_bus_i; // RQ9
					chan_d  = channel_address_i; // RQ10
					reg_d   = register_select_i; // RQ10
					// normal mode always lands in register A
					bank_d  = toggle_mode_i && sdo_bank_i; // RQ11
				end
			end
			hps_pkg::HPS_MODE_SPI: begin
				sync_d   = shared_sel_i; // RQ6
				chain_d  = shared_wr_i; // RQ7
				sdo_d    = serial_dout_i;
				sdo_oe_d = 1'b1;
			end
			hps_pkg::HPS_MODE_I2C: begin
				i2c_d = {shared_wr_i, shared_sel_i}; // RQ8
			end
			default: begin
				// unused code: fall back to parallel on the next edge
				mode_d = hps_pkg::HPS_MODE_PAR;
			end
		endcase
	end

	// pin role registers; a low enable freezes everything
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_q   <= hps_pkg::MODE_RST;
			wr_q     <= 1'b1;
			sel_q    <= 1'b0;
			write_q  <= 1'b0;
			data_q   <= hps_pkg::DATA_RST;
			chan_q   <= hps_pkg::ADDR_RST;
			reg_q    <= hps_pkg::REG_RST;
			bank_q   <= 1'b0;
			sync_q   <= 1'b1;
			chain_q  <= 1'b0;
			i2c_q    <= hps_pkg::I2C_RST;
			sdo_q    <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else if (clk_en_i) begin
			mode_q   <= mode_d;
			wr_q     <= wr_d;
			sel_q    <= sel_d;
			write_q  <= write_d;
			data_q   <= data_d;
			chan_q   <= chan_d;
			reg_q    <= reg_d;
			bank_q   <= bank_d;
			sync_q   <= sync_d;
			chain_q  <= chain_d;
			i2c_q    <= i2c_d;
			sdo_q    <= sdo_d;
			sdo_oe_q <= sdo_oe_d;
		end
	end

	// next monitor switch state
	always_comb begin
		route_d  = mon.route; // RQ1
		active_d = |mon.route;
	end

	// monitor registers: switches change on a clean edge, never glitch
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			route_q  <= hps_pkg::ROUTE_RST;
			active_q <= 1'b0;
		end else if (clk_en_i) begin
			route_q  <= route_d;
			active_q <= active_d;
		end
	end

	// outputs straight from the registers
	assign mode_o           = mode_q;
	assign par_selected_o   = sel_q;
	assign par_write_o      = write_q;
	assign par_data_o       = data_q;
	assign par_chan_o       = chan_q;
	assign par_reg_o        = reg_q;
	assign par_bank_b_o     = bank_q;
	assign frame_sync_o     = sync_q;
	assign spi_chain_en_o   = chain_q;
	assign i2c_addr_o       = i2c_q;
	assign sdo_bank_o       = sdo_q;
	assign sdo_bank_oe_o    = sdo_oe_q;
	assign monitor_output_o = route_q;
	assign monitor_active_o = active_q;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	// a qualified strobe rise in parallel mode with the device selected
	sequence s_par_rise;
		clk_en_i && mode_q == hps_pkg::HPS_MODE_PAR && !shared_sel_i
			&& shared_wr_i && !wr_q;
	endsequence

	// the write seen one edge later with the captured word
	sequence s_par_done;
		par_write_o && par_data_o == $past(parallel_data_bus_i)
			&& par_chan_o == $past(channel_address_i);
	endsequence

	chk_mon_onehot: assert property ( // RQ1
		monitor_active_o |-> $onehot(monitor_output_o))
		else $error("monitor route not one-hot");
	chk_mon_route_sel: assert property ( // RQ1
		clk_en_i && monitor_enable_i && monitor_select_i < 6'h24
		|=> monitor_output_o[$past(monitor_select_i)] && monitor_active_o)
		else $error("monitor source not routed");
	chk_mode_serial_pick: assert property ( // RQ2
		clk_en_i && interface_select_i
		|=> mode_o == ($past(proto_select_i) ? 2'h3 : 2'h1))
		else $error("serial mode not taken");
	chk_mode_parallel: assert property ( // RQ3
		clk_en_i && !interface_select_i |=> mode_o == 2'h0)
		else $error("parallel mode not taken");
	chk_par_write_gate: assert property ( // RQ4
		par_write_o |-> par_selected_o && $past(mode_q) == 2'h0)
		else $error("write without device select");
	chk_par_write_data: assert property ( // RQ5
		s_par_rise |=> s_par_done)
		else $error("parallel write missed");
	chk_par_write_pulse: assert property ( // RQ5
		par_write_o && clk_en_i |=> !par_write_o)
		else $error("write pulse too long");
	chk_frame_sync: assert property ( // RQ6
		clk_en_i && mode_q == hps_pkg::HPS_MODE_SPI
		|=> frame_sync_o == $past(shared_sel_i))
		else $error("frame sync not following pin");
	// gated by the enable so a frozen chain flag is not held against the pin
	chk_chain_only_spi: assert property ( // RQ7
		clk_en_i |=> spi_chain_en_o
			== ($past(mode_q) == hps_pkg::HPS_MODE_SPI && $past(shared_wr_i)))
		else $error("chain enable outside spi");
	chk_i2c_addr_bits: assert property ( // RQ8
		clk_en_i && mode_q == hps_pkg::HPS_MODE_I2C
		|=> i2c_addr_o == {$past(shared_wr_i), $past(shared_sel_i)})
		else $error("i2c address bits wrong");
	chk_bank_default_a: assert property ( // RQ11
		s_par_rise ##0 !toggle_mode_i |=> !par_bank_b_o)
		else $error("normal mode wrote register b");
endmodule
`default_nettype wire

// ==== bench/hps_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// host side of the pins: every line moves 1 ns after a rising edge
module hps_host_model (
	// clock
	input  wire logic   clk_sys_i,
	// straps and shared pins
	output logic        ser_o,
	output logic        proto_o,
	output logic        sel_o,
	output logic        wr_o,
	// parallel bus and bank
	output logic [11:0] data_o,
	output logic [4:0]  chan_o,
	output logic [1:0]  reg_o,
	output logic        tog_o,
	output logic        bank_o
);
	// deselected with the strobe idle high
	initial begin
		{ser_o, proto_o, sel_o, wr_o, tog_o, bank_o} = 6'h0c;
		{data_o, chan_o, reg_o} = 19'h0;
	end
	// straps move only while idle, then settle for two edges
	task automatic set_mode(input logic s, input logic p);
		@(posedge clk_sys_i);
		#1;
		{ser_o, proto_o} = {s, p};
		repeat (2) @(posedge clk_sys_i);
		#2; // return settled, so a caller may look at the outputs at once
	endtask
	// hold a level on the shared pins
	task automatic pins(input logic s, input logic w);
		@(posedge clk_sys_i);
		#1;
		{sel_o, wr_o} = {s, w};
	endtask
	// word set up a cycle ahead of the strobe rise, held past it
	task automatic par_write(input logic c, input logic [11:0] d,
		input logic [4:0] a, input logic [1:0] r, input logic [1:0] tb);
		@(posedge clk_sys_i);
		#1;
		{sel_o, wr_o, tog_o, bank_o} = {c, 1'b0, tb};
		{data_o, chan_o, reg_o} = {d, a, r};
		@(posedge clk_sys_i);
		#1;
		wr_o = 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1;
		sel_o = 1'b1;
		data_o = ~d; // a released bus must not look like the last word
	endtask
endmodule
`default_nettype wire

// ==== bench/hps_pin_select_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// self-checking bench: host model on the pins, bench on the rest
module hps_pin_select_tb;
	logic        clk_sys_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        dout = 1'b0;
	logic        en = 1'b1;
	logic        mon_en = 1'b0;
	logic [5:0]  mon_sel = 6'h00;
	logic        ser, proto, sel, wr, tog, bank, sdo, oe;
	logic [11:0] data, pdata;
	logic [4:0]  chan, pchan;
	logic [1:0]  rsel, mode, preg, i2c;
	logic        psel, pw, pbank, fsync, chain, mact;
	logic [35:0] mon;
	int          n_fail = 0;
	int          checks = 0;
	int          n_pw = 0;
	// the two-way pin: device drives it only while enabled
	wire logic   pin = oe ? sdo : bank;
	// clock, and a count of write pulses seen at each edge
	always #50 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (pw === 1'b1) begin
			n_pw++;
		end
	end
	hps_host_model host (.clk_sys_i, .ser_o(ser), .proto_o(proto),
		.sel_o(sel), .wr_o(wr), .data_o(data), .chan_o(chan),
		.reg_o(rsel), .tog_o(tog), .bank_o(bank));
	hps_pin_select DUT (.clk_sys_i, .resetn_i, .clk_en_i(en),
		.interface_select_i(ser), .proto_select_i(proto),
		.shared_sel_i(sel), .shared_wr_i(wr), .parallel_data_bus_i(data),
		.channel_address_i(chan), .register_select_i(rsel),
		.toggle_mode_i(tog), .sdo_bank_i(pin), .sdo_bank_o(sdo),
		.sdo_bank_oe_o(oe), .serial_dout_i(dout),
		.monitor_enable_i(mon_en), .monitor_select_i(mon_sel),
		.mode_o(mode), .par_selected_o(psel), .par_write_o(pw),
		.par_data_o(pdata), .par_chan_o(pchan), .par_reg_o(preg),
		.par_bank_b_o(pbank), .frame_sync_o(fsync),
		.spi_chain_en_o(chain), .i2c_addr_o(i2c),
		.monitor_output_o(mon), .monitor_active_o(mact));
	// compare and count
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// two edges, then settle before looking
	task automatic tick();
		repeat (2) @(posedge clk_sys_i);
		#2;
	endtask
	task automatic print_verdict();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// every register class, boundary words, bank in both modes
	task automatic t_par();
		int n0;
		logic [11:0] w [4] = '{12'hfff, 12'h800, 12'h001, 12'h5a5};
		for (int k = 0; k < 4; k++) begin
			n0 = n_pw;
			host.par_write(1'b0, w[k], 5'h1f ^ 5'(k), 2'(k), {k[0], 1'b1});
			tick();
			chk(36'(n_pw - n0), 36'h1);
			chk(pdata, 36'(w[k]));
			chk({pchan, preg}, 36'({5'h1f ^ 5'(k), 2'(k)}));
			chk(pbank, 36'(k[0]));
		end
	endtask
	// strobe while deselected is ignored; select follows the pin
	task automatic t_refuse();
		int n0;
		n0 = n_pw;
		host.par_write(1'b1, 12'h3c3, 5'h00, 2'h0, 2'b00);
		tick();
		chk(36'(n_pw - n0), 36'h0);
		chk(pdata, 36'h5a5);
		host.pins(1'b0, 1'b1);
		tick();
		chk(psel, 36'h1);
		host.pins(1'b1, 1'b1);
		tick();
		chk(psel, 36'h0);
	endtask
	// spi roles of the shared pins; parallel strobes refused
	task automatic t_spi();
		int n0;
		host.set_mode(1'b1, 1'b0);
		chk({mode, oe}, 36'h3);
		host.pins(1'b0, 1'b1);
		dout = 1'b1;
		tick();
		chk({fsync, chain, sdo}, 36'h3);
		host.pins(1'b1, 1'b0);
		tick();
		chk({fsync, chain}, 36'h2);
		n0 = n_pw;
		host.par_write(1'b0, 12'h0f0, 5'h03, 2'h3, 2'b00);
		tick();
		chk(36'(n_pw - n0), 36'h0);
	endtask
	// i2c address bits, then back to parallel
	task automatic t_i2c();
		host.set_mode(1'b1, 1'b1);
		chk(mode, 36'h3);
		for (int k = 0; k < 4; k++) begin
			host.pins(k[0], k[1]);
			tick();
			chk(i2c, 36'(k));
			chk({fsync, chain, oe}, 36'h4);
		end
		host.set_mode(1'b0, 1'b0);
		chk({mode, fsync, chain, oe}, 36'h4);
	endtask
	// all 64 selects, one with monitoring off
	task automatic t_mon();
		for (int k = 0; k < 64; k++) begin
			@(posedge clk_sys_i);
			#1;
			mon_en = (k != 7);
			mon_sel = 6'(k);
			tick();
			chk(mon, (k != 7 && k < 36) ? 36'h1 << k : 36'h0);
			chk(mact, 36'(k != 7 && k < 36));
		end
	endtask
	// a low enable freezes every register, so a strobe meanwhile is lost;
	// the monitor select moved while frozen is taken once enabled again
	task automatic t_hold();
		int n0;
		n0 = n_pw;
		@(posedge clk_sys_i);
		#1;
		en = 1'b0;
		mon_sel = 6'h21;
		host.par_write(1'b0, 12'h0c3, 5'h02, 2'h1, 2'b00);
		tick();
		chk(36'(n_pw - n0), 36'h0);
		chk(pdata, 36'h5a5);
		chk(mon, 36'h0);
		@(posedge clk_sys_i);
		#1;
		en = 1'b1;
		tick();
		chk(mon, 36'h1 << 33);
		chk(mact, 36'h1);
		chk(36'(n_pw - n0), 36'h0);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_i);
		chk({mode, fsync, chain, pw, mact, psel}, 36'h10);
		#1;
		resetn_i = 1'b1;
		tick();
		t_par();
		t_refuse();
		t_spi();
		t_i2c();
		t_mon();
		t_hold();
		print_verdict();
	end
	// a hang ends the run as a failure
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire
